//--- rcp_pkg.sv
// Functional notes
// - Brown-out and power-on resets clear brown-out flag.
// - Low-power brown-out forces full power-on reset.
// - Configuration compared with inverted shadow continuously.
// - Mismatch clears its flag; power-on and brown-out set it, others leave it.
// - Mismatch acts as pin reset; reload configuration.
// - Power-up timer runs only when enabled.
// - Power-up timer: 11 bits, slow oscillator.
// - Internal reset held while timer counts.
// - Timer starts after power-on pulse ends.
// - Late pin release starts execution at once.
// - Reset class selects which registers reset.
// - Watchdog wake is resume, not reset.
// - Power-on flags, stack flags, program counter zero.
// - Reset instruction and brown-out flag effects.
// - Pin reset flag effects depend on mode.
// - Stack full and underflow flags, reset enable.
// - Watchdog time-out resets or wakes by mode.
// - Interrupt wake clears power-down, continues sequentially.
// - Enabled interrupt wake loads interrupt vector.
// - Only software sets the power-on flag.
// - Watchdog-clear sets time-out and power-down; sleep sets time-out, clears power-down.
package rcp_pkg;

  localparam int unsigned PC_W = 21;  // Program counter width.
  localparam int unsigned PT_W = 11;  // Power-up timer width.
  localparam logic [PT_W-1:0] PT_LAST = 11'h7ff;  // Last timer count.

  // Register byte addresses on the bus.
  localparam logic [7:0] A_RESET_CONTROL_REG = 8'h00;  // Reset control register.
  localparam logic [7:0] A_STK  = 8'h04;  // Stack flag register.
  localparam logic [7:0] A_CFG  = 8'h08;  // Live configuration bits.
  localparam logic [7:0] A_STAT = 8'h0c;  // Sequencer status.

  // Field positions of the reset control register.
  localparam int unsigned B_BOR  = 0;
  localparam int unsigned B_POR  = 1;
  localparam int unsigned B_PD   = 2;
  localparam int unsigned B_TO   = 3;
  localparam int unsigned B_RI   = 4;
  localparam int unsigned B_CM   = 5;
  localparam logic [7:0]  RESET_CONTROL_REG_RST   = 8'h3c;  // Value after power-on.
  localparam logic [7:0]  RESET_CONTROL_REG_WMASK = 8'hb3;  // Software-writable bits.

  // Stack flags sit in bits 7:6 of their register.
  localparam int unsigned K_UNF   = 0;
  localparam int unsigned K_FULL  = 1;
  localparam int unsigned STK_LSB = 6;

  // Configuration bits and status layout.
  localparam int unsigned C_PTEN = 0;  // Power-up timer enable.
  localparam int unsigned C_STV  = 1;  // Stack overflow reset enable.
  localparam int unsigned ST_LSB = 16;  // Sequencer state field.

  // Program counter values.
  localparam logic [PC_W-1:0] PC_ZERO = 21'h0_0000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
  localparam logic [PC_W-1:0] VEC_HI  = 21'h0_0008;
  localparam logic [PC_W-1:0] VEC_LO  = 21'h0_0018;

  // Power modes; bit 1 high means the CPU is halted.
  localparam logic [1:0] PM_FULL = 2'h0;
  localparam logic [1:0] PM_RUN  = 2'h1;

  // Reset classes reported to the register file.
  localparam logic [1:0] RC_NONE  = 2'h0;
  localparam logic [1:0] RC_POWER = 2'h1;
  localparam logic [1:0] RC_HARD  = 2'h2;
  localparam logic [1:0] RC_WAKE  = 2'h3;

  // Synchroniser lanes.
  localparam int unsigned SY_PIN = 0;
  localparam int unsigned SY_POR = 1;
  localparam int unsigned SY_BOR = 2;
  localparam int unsigned SY_LPB = 3;
  localparam int unsigned SY_LF  = 4;

  typedef enum logic [1:0] {
    ST_POR = 2'b00, ST_POWERUP_TIMER = 2'b01, ST_HOLD = 2'b11, ST_RUN = 2'b10
  } rcp_st_e;

  typedef enum logic [3:0] {
    EV_NONE, EV_POR, EV_BOR, EV_PIN, EV_CM, EV_WDT_RST, EV_WDT_WAKE,
    EV_RSTI, EV_FULL, EV_UNF, EV_UNF_ERR, EV_IRQ
  } rcp_ev_e;

  // Events and context from the CPU core.
  typedef struct packed {
    logic            wdog_timeout;
    logic            watchdog_clear_instr;
    logic            sleep_instr;
    logic            reset_instr;
    logic            stack_full;
    logic            stack_underflow;
    logic            irq_wake;
    logic            irq_high_pri;
    logic            global_irq_enable_high;
    logic            global_irq_enable_low;
    logic [1:0]      pm_mode;
    logic [PC_W-1:0] cur_pc;
  } rcp_core_ev_s;

  // Controls returned to the core.
  typedef struct packed {
    logic            core_reset;
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            cfg_reload;
    logic [1:0]      reset_class;
    logic [1:0]      cfg_bits;
  } rcp_ctl_s;

  // Whole state of the block.
  typedef struct packed {
    logic [4:0]      sy1;
    logic [4:0]      sy2;
    logic            lf_prev;
    rcp_st_e         st;
    logic [PT_W-1:0] cnt;
    logic [7:0]      reset_control_reg;
    logic [1:0]      stk;
    logic [1:0]      cfg;
    logic [1:0]      shd;
    rcp_ctl_s        ctl;
    logic            ack;
    logic [31:0]     dat;
  } rcp_state_s;

  localparam rcp_state_s S_RST = '{
    st: ST_POR, reset_control_reg: RESET_CONTROL_REG_RST, shd: 2'h3,
    ctl: '{core_reset: 1'b1, default: '0}, default: '0};

endpackage : rcp_pkg

//--- rcp_reset_ctrl.sv
module rcp_reset_ctrl
  import rcp_pkg::*;
(
  input  wire logic         core_clk,             // System clock, 50 MHz.
  input  wire logic         rst,                  // Synchronous reset, high.
  input  wire logic         clk_en,               // Freezes all state when low.
  input  wire logic         wb_cyc_i,             // Bus cycle.
  input  wire logic         wb_stb_i,             // Bus strobe.
  input  wire logic         wb_we_i,              // Bus write.
  input  wire logic [7:0]   wb_adr_i,             // Bus byte address.
  input  wire logic [3:0]   wb_sel_i,             // Bus byte enables.
  input  wire logic [31:0]  wb_dat_i,             // Bus write data.
  output logic      [31:0]  wb_dat_o,             // Bus read data.
  output logic              wb_ack_o,             // Bus acknowledge.
  input  wire logic         external_reset_pin_n, // Reset pin, low resets.
  input  wire logic         por_pulse,            // Power-on detector.
  input  wire logic         brownout_det,         // Brown-out detector.
  input  wire logic         low_power_brownout,   // Low-power detector.
  input  wire logic         low_freq_internal_osc, // Slow oscillator.
  input  wire logic [1:0]   flash_cfg,            // Stored configuration.
  input  wire logic [1:0]   cfg_upset,            // Fault flips of config.
  input  rcp_core_ev_s      core_ev,              // Core events.
  output rcp_ctl_s          core_ctl              // Controls to the core.
);

  rcp_state_s q;       // Registered state.
  rcp_state_s d;       // Next state.
  rcp_ev_e    ev;      // Event chosen this cycle.
  logic       lf_tick; // Rising edge of the slow oscillator.
  logic       pin_hi;  // Synchronised pin level.
  logic       por_on;  // Power-on condition present.
  logic       bor_on;  // Brown-out condition present.
  logic       mism;    // Configuration differs from shadow.
  logic       sleepy;  // Core in idle or sleep.
  logic       run;     // Sequencer lets code run.
  logic       req;     // Bus request present.
  logic       wr;      // Write takes effect this edge.
  logic       wr_reset_control_reg; // Write to the reset control register.
  logic       gie;     // Any global interrupt enable set.
  logic [31:0] rd;     // Read word for the addressed register.

  // Only the second synchroniser stage and the edge flop are read here.
  assign lf_tick = q.sy2[SY_LF] & ~q.lf_prev;
  assign pin_hi  = q.sy2[SY_PIN];
  // A low-power brown-out re-arms the detector: it counts as power-on.
  assign por_on  = q.sy2[SY_POR] | q.sy2[SY_LPB];
  assign bor_on  = q.sy2[SY_BOR];
  // Live bits must always equal the complement of their shadow.
  assign mism    = (q.cfg != ~q.shd);
  assign sleepy  = core_ev.pm_mode[1];
  assign run     = (q.st == ST_RUN);
  assign gie     = core_ev.global_irq_enable_high | core_ev.global_irq_enable_low;

  // Writes land on the edge where the master samples ack.
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr      = q.ack & req & wb_we_i & wb_sel_i[0];
  assign wr_reset_control_reg = wr & (wb_adr_i == A_RESET_CONTROL_REG);

  // Event priority: supply events first, then the pin, then core events.
  // Core events only count while code runs; in reset they cannot occur.
  always_comb begin
    ev = EV_NONE;
    if (por_on) begin
      ev = EV_POR;
    end else if (bor_on) begin
      ev = EV_BOR;
    end else if (run) begin
      if (!pin_hi) begin
        ev = EV_PIN;
      end else if (mism) begin
        ev = EV_CM;
      end else if (core_ev.wdog_timeout) begin
        ev = sleepy ? EV_WDT_WAKE : EV_WDT_RST;
      end else if (core_ev.reset_instr) begin
        ev = EV_RSTI;
      end else if (core_ev.stack_full && q.cfg[C_STV]) begin
        ev = EV_FULL;
      end else if (core_ev.stack_underflow) begin
        ev = q.cfg[C_STV] ? EV_UNF : EV_UNF_ERR;
      end else if (core_ev.irq_wake && sleepy) begin
        ev = EV_IRQ;
      end
    end
  end

  // Read mux; unmapped addresses read as zero but are still answered.
  always_comb begin
    rd = '0;
    case (wb_adr_i)
      A_RESET_CONTROL_REG: begin
        rd[7:0] = q.reset_control_reg;
      end
      A_STK: begin
        rd[STK_LSB +: 2] = q.stk;
      end
      A_CFG: begin
        rd[1:0] = q.cfg;
      end
      A_STAT: begin
        rd[PT_W-1:0]    = q.cnt;
        rd[ST_LSB +: 2] = q.st;
      end
      default: begin
        rd = '0;
      end
    endcase
  end

  // Next-state logic. Order matters: software writes first, then
  // hardware effects, so an event in the cycle of a write always wins.
  always_comb begin
    d = q;

    // Two-flop synchronisers for every asynchronous input.
    d.sy1 = {low_freq_internal_osc, low_power_brownout, brownout_det,
             por_pulse, external_reset_pin_n};
    d.sy2 = q.sy1;
    d.lf_prev = q.sy2[SY_LF];

    // Bus slave: ack one cycle after the request, drop it the next.
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.dat = rd;
    end
    if (wr) begin
      case (wb_adr_i)
        A_RESET_CONTROL_REG: begin
          // Only software can return the power-on flag to one.
          d.reset_control_reg = (q.reset_control_reg & ~RESET_CONTROL_REG_WMASK) | (wb_dat_i[7:0] & RESET_CONTROL_REG_WMASK);
        end
        A_STK: begin
          d.stk = wb_dat_i[STK_LSB +: 2];
        end
        A_CFG: begin
          d.cfg = wb_dat_i[1:0];
          d.shd = ~wb_dat_i[1:0];
        end
        default: begin
          d.dat = q.dat;
        end
      endcase
    end

    // A fault flips live bits but not the shadow, so it is caught.
    d.cfg = d.cfg ^ cfg_upset;

    // Watchdog-clear and sleep instructions while running normally.
    if (run && ev == EV_NONE) begin
      if (core_ev.watchdog_clear_instr) begin
        d.reset_control_reg[B_TO] = 1'b1;
        d.reset_control_reg[B_PD] = 1'b1;
      end else if (core_ev.sleep_instr) begin
        d.reset_control_reg[B_TO] = 1'b1;
        d.reset_control_reg[B_PD] = 1'b0;
      end
    end

    // Pulses default low.
    d.ctl.pc_load     = 1'b0;
    d.ctl.cfg_reload  = 1'b0;
    d.ctl.reset_class = RC_NONE;

    // Power-up sequencer.
    case (q.st)
      ST_POR: begin
        // The timer starts only once the power-on pulse is gone.
        if (!por_on && !bor_on) begin
          d.cnt = '0;
          if (q.cfg[C_PTEN]) begin
            d.st = ST_POWERUP_TIMER;
          end else begin
            d.st = pin_hi ? ST_RUN : ST_HOLD;
          end
        end
      end
      ST_POWERUP_TIMER: begin
        // Counts slow-oscillator edges; the pin does not stop it.
        if (lf_tick) begin
          if (q.cnt == PT_LAST) begin
            d.st = pin_hi ? ST_RUN : ST_HOLD;
          end else begin
            d.cnt = q.cnt + 1'b1;
          end
        end
      end
      ST_HOLD: begin
        // Timer expired or not run: the pin release starts code at once.
        if (pin_hi) begin
          d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        d.st = ST_RUN;
      end
      default: begin
        d.st = ST_POR;
      end
    endcase

    // Effects of the chosen event on flags, sequencer and counter.
    case (ev)
      EV_POR: begin
        d.reset_control_reg = RESET_CONTROL_REG_RST;
        d.stk  = '0;
        d.st   = ST_POR;
        d.cnt  = '0;
      end
      EV_BOR: begin
        d.reset_control_reg[B_CM]  = 1'b1;
        d.reset_control_reg[B_RI]  = 1'b1;
        d.reset_control_reg[B_TO]  = 1'b1;
        d.reset_control_reg[B_PD]  = 1'b1;
        d.reset_control_reg[B_BOR] = 1'b0;
        d.st  = ST_POR;
        d.cnt = '0;
      end
      EV_PIN: begin
        // No flag moves during full-power execution.
        if (core_ev.pm_mode != PM_FULL) begin
          d.reset_control_reg[B_TO] = 1'b1;
        end
        if (sleepy) begin
          d.reset_control_reg[B_PD] = 1'b0;
        end
      end
      EV_CM: begin
        d.reset_control_reg[B_CM] = 1'b0;
      end
      EV_WDT_RST: begin
        d.reset_control_reg[B_TO] = 1'b0;
      end
      EV_WDT_WAKE: begin
        d.reset_control_reg[B_TO] = 1'b0;
        d.reset_control_reg[B_PD] = 1'b0;
        d.ctl.pc_load  = 1'b1;
        d.ctl.pc_value = core_ev.cur_pc + PC_STEP;
        d.ctl.reset_class = RC_WAKE;
      end
      EV_RSTI: begin
        d.reset_control_reg[B_RI] = 1'b0;
      end
      EV_FULL: begin
        d.stk[K_FULL] = 1'b1;
      end
      EV_UNF, EV_UNF_ERR: begin
        d.stk[K_UNF] = 1'b1;
      end
      EV_IRQ: begin
        // Wake from interrupt: vector if enabled, else next word.
        d.reset_control_reg[B_PD] = 1'b0;
        d.ctl.pc_load = 1'b1;
        if (gie) begin
          d.ctl.pc_value = core_ev.irq_high_pri ? VEC_HI : VEC_LO;
        end else begin
          d.ctl.pc_value = core_ev.cur_pc + PC_STEP;
        end
        d.ctl.reset_class = RC_WAKE;
      end
      default: begin
        d.ctl.pc_load = 1'b0;
      end
    endcase

    // Every real reset restarts at zero and reloads the configuration.
    // A mismatch reset takes the same path as a pin reset.
    if (ev inside {EV_POR, EV_BOR, EV_PIN, EV_CM, EV_WDT_RST, EV_RSTI,
                   EV_FULL, EV_UNF}) begin
      d.ctl.pc_load    = 1'b1;
      d.ctl.pc_value   = PC_ZERO;
      d.ctl.cfg_reload = 1'b1;
      d.cfg = flash_cfg;
      d.shd = ~flash_cfg;
      if (ev == EV_POR || ev == EV_BOR) begin
        d.ctl.reset_class = RC_POWER;
      end else begin
        d.ctl.reset_class = RC_HARD;
        d.st = ST_HOLD;
      end
    end

    // Reset is held everywhere except in the running state.
    d.ctl.core_reset = (d.st != ST_RUN);
    d.ctl.cfg_bits   = d.cfg;
  end

  // Single state register; the enable freezes everything.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= S_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign core_ctl = q.ctl;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Power-on leaves the documented flag pattern.
  por_flags_a: assert property (
    clk_en && por_on |=> !q.reset_control_reg[B_POR] && !q.reset_control_reg[B_BOR]
      && q.reset_control_reg[B_CM] && q.reset_control_reg[B_TO] && q.stk == '0)
    else $error("Power-on flags wrong.");

  // Counting always keeps the core in reset.
  powerup_timer_hold_a: assert property (
    q.st == ST_POWERUP_TIMER |-> q.ctl.core_reset)
    else $error("Core released while timer counts.");

  // Each slow edge before the last count advances the counter by exactly one.
  powerup_timer_count_a: assert property (
    clk_en && q.st == ST_POWERUP_TIMER && lf_tick && q.cnt != PT_LAST
      && !por_on && !bor_on
    |=> q.cnt == $past(q.cnt) + 11'h001)
    else $error("Timer step wrong.");

  // With the enable clear the timer is skipped.
  powerup_timer_skip_a: assert property (
    clk_en && q.st == ST_POR && !por_on && !bor_on && !q.cfg[C_PTEN]
    |=> q.st != ST_POWERUP_TIMER)
    else $error("Timer ran while disabled.");

  // Nothing starts while the power-on pulse lasts.
  por_wait_a: assert property (
    clk_en && por_on |=> q.st == ST_POR && q.cnt == '0)
    else $error("Timer started during power-on pulse.");

  // Pin release after expiry frees the core on the next edge.
  pin_release_a: assert property (
    clk_en && q.st == ST_HOLD && pin_hi && !por_on && !bor_on
    |=> !q.ctl.core_reset && q.st == ST_RUN)
    else $error("Late pin release not immediate.");

  // Mismatch clears its flag and reloads configuration.
  cm_flag_a: assert property (
    clk_en && ev == EV_CM
    |=> !q.reset_control_reg[B_CM] && q.ctl.cfg_reload && q.ctl.core_reset)
    else $error("Mismatch reset handled wrong.");

  // Watchdog wake resumes two bytes on without reset.
  wdt_wake_a: assert property (
    clk_en && ev == EV_WDT_WAKE
    |=> q.ctl.pc_load && q.ctl.pc_value == $past(core_ev.cur_pc) + PC_STEP
      && !q.reset_control_reg[B_TO] && !q.reset_control_reg[B_PD] && !q.ctl.core_reset)
    else $error("Watchdog wake wrong.");

  // Enabled interrupt wake goes to its vector.
  irq_vector_a: assert property (
    clk_en && ev == EV_IRQ && gie
    |=> q.ctl.pc_value == ($past(core_ev.irq_high_pri) ? VEC_HI : VEC_LO))
    else $error("Interrupt vector wrong.");

  // The power-on flag only rises through a bus write.
  por_soft_a: assert property (
    $rose(q.reset_control_reg[B_POR]) |-> $past(wr_reset_control_reg))
    else $error("Power-on flag set by hardware.");

endmodule : rcp_reset_ctrl

//--- rcp_far_end.sv
module rcp_far_end (
  input  wire logic core_clk,              // System clock.
  input  wire logic hold_low,              // Bench request to pull the pin low.
  output logic      external_reset_pin_n,  // Reset pin, pulled up when released.
  output logic      low_freq_internal_osc  // Slow oscillator, free running.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       pin_q = 1'b0;   // Pin starts low, as a supply ramps with the pin.
  logic [1:0] div_q = 2'h0;   // Divider for the slow oscillator.

  // The real oscillator is far slower; a period of four clocks keeps the run short
  // while each tick still spans two samples of the synchroniser.
  always_ff @(posedge core_clk) begin
    pin_q <= ~hold_low;
    div_q <= div_q + 2'h1;
  end

  assign external_reset_pin_n  = pin_q;
  assign low_freq_internal_osc = div_q[1];
endmodule : rcp_far_end

//--- tb.sv
module tb
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         core_clk, rst, cyc, stb, we, ack, pin_hold, pin_n, osc, por, bor_det, lpb, en;
  logic [7:0]   adr;        // Bus address.
  logic [31:0]  wdat, rdat; // Bus write data and last read word.
  logic [31:0]  dat_o;      // Read data from the block.
  logic [1:0]   fcfg, upset; // Stored configuration and fault flips.
  logic [7:0]   x;          // Expected reset control flags.
  rcp_core_ev_s cev, base, e; // Core events, idle levels, scratch.
  rcp_ctl_s     ctl;        // Controls to the core.
  int           n_errors, checked, cyc_cnt, n;
  logic [1:0]   pms [3] = '{2'h0, 2'h1, 2'h3}; // Full, run and sleep.

  rcp_reset_ctrl dut (.core_clk(core_clk), .rst(rst), .clk_en(en), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .external_reset_pin_n(pin_n), .por_pulse(por),
    .brownout_det(bor_det), .low_power_brownout(lpb), .low_freq_internal_osc(osc),
    .flash_cfg(fcfg), .cfg_upset(upset), .core_ev(cev), .core_ctl(ctl));

  rcp_far_end far (.core_clk(core_clk), .hold_low(pin_hold), .external_reset_pin_n(pin_n),
    .low_freq_internal_osc(osc));

  // Free-running 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // One classic bus cycle; the request is held until ack is seen at an edge.
  // Only the bench timeout ends a wait for ack.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic reset_control_reg_is(input logic [7:0] f);
    bus(1'b0, A_RESET_CONTROL_REG, 32'h0000_0000);
    chk(rdat, {24'h00_0000, f});
  endtask : reset_control_reg_is

  // Holds one event for one cycle; the answer is read as it stands at the next edge.
  task automatic ev(input rcp_core_ev_s s);
    cev <= s;
    @(posedge core_clk);
    cev <= base;
    @(posedge core_clk);
  endtask : ev

  task automatic run_wait;
    n = 0;
    while (ctl.core_reset !== 1'b0) begin
      @(posedge core_clk);
      n++;
    end
  endtask : run_wait

  task automatic fire(input rcp_core_ev_s s, input logic [20:0] pc, input logic [1:0] cls);
    ev(s);
    chk(32'({ctl.pc_load, ctl.reset_class, ctl.pc_value}), 32'({1'b1, cls, pc}));
    run_wait();
  endtask : fire

  // Cuts a hang short and still gives a verdict.
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 45000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      stop_test();
    end
  end

  initial begin
    {rst, por, fcfg} = {1'b1, 1'b1, 2'h1};
    {cyc, stb, we, pin_hold, bor_det, lpb, adr, wdat, upset} = '0;
    {n_errors, checked, cyc_cnt} = '0;
    en = 1'b1;
    base = '0;
    base.cur_pc = 21'h0_1234;
    cev = base;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    por <= 1'b0;
    repeat (6) @(posedge core_clk);
    bus(1'b0, A_STAT, 32'h0000_0000);
    chk(32'(rdat[17:16]), 32'h0000_0001);
    chk(32'(ctl.core_reset), 32'h0000_0001);
    run_wait();
    chk(32'(n > 8150 && n < 8220), 32'h0000_0001);
    chk(32'(ctl.cfg_bits), 32'h0000_0001);
    fcfg <= 2'h0;
    x = 8'h3c;
    reset_control_reg_is(x);
    bus(1'b1, A_RESET_CONTROL_REG, 32'h0000_00ff);
    x = 8'hbf;
    reset_control_reg_is(x);
    $display("power-up test done");
    e = base;
    e.reset_instr = 1'b1;
    fire(e, 21'h0_0000, RC_HARD);
    chk(32'(ctl.cfg_bits), 32'h0000_0000);
    x[4] = 1'b0;
    reset_control_reg_is(x);
    e = base;
    e.wdog_timeout = 1'b1;
    fire(e, 21'h0_0000, RC_HARD);
    x[3] = 1'b0;
    reset_control_reg_is(x);
    e = base;
    e.watchdog_clear_instr = 1'b1;
    ev(e);
    x[3:2] = 2'h3;
    reset_control_reg_is(x);
    e = base;
    e.sleep_instr = 1'b1;
    ev(e);
    x[3:2] = 2'h2;
    reset_control_reg_is(x);
    e = base;
    e.wdog_timeout = 1'b1;
    e.pm_mode = 2'h3;
    fire(e, 21'h0_1236, RC_WAKE);
    chk(32'(n), 32'h0000_0000);
    x[3:2] = 2'h0;
    reset_control_reg_is(x);
    // A plain wake resumes after the sleep; enabled ones take a vector.
    for (int k = 0; k < 3; k++) begin
      e = base;
      e.watchdog_clear_instr = 1'b1;
      ev(e);
      e = base;
      e.pm_mode = 2'h2;
      e.irq_wake = 1'b1;
      e.irq_high_pri = (k == 1);
      e.global_irq_enable_high = (k == 1);
      e.global_irq_enable_low = (k == 2);
      fire(e, (k == 0) ? 21'h0_1236 : (k == 1) ? 21'h0_0008 : 21'h0_0018, RC_WAKE);
      x[3:2] = 2'h2;
      reset_control_reg_is(x);
    end
    // A frozen block must not take an instruction strobe.
    en <= 1'b0;
    e = base;
    e.watchdog_clear_instr = 1'b1;
    ev(e);
    en <= 1'b1;
    reset_control_reg_is(x);
    $display("event test done");
    // Each pin reset starts from time-out flag clear and power-down flag set.
    for (int k = 0; k < 3; k++) begin
      e = base;
      e.watchdog_clear_instr = 1'b1;
      ev(e);
      e = base;
      e.wdog_timeout = 1'b1;
      fire(e, 21'h0_0000, RC_HARD);
      x[3:2] = 2'h1;
      base.pm_mode = pms[k];
      cev <= base;
      pin_hold <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(32'(ctl.core_reset), 32'h0000_0001);
      pin_hold <= 1'b0;
      run_wait();
      if (k > 0)
        x[3] = 1'b1;
      if (k == 2)
        x[2] = 1'b0;
      reset_control_reg_is(x);
    end
    base.pm_mode = 2'h0;
    cev <= base;
    $display("pin test done");
    bus(1'b1, A_CFG, 32'h0000_0002);
    e = base;
    e.stack_full = 1'b1;
    fire(e, 21'h0_0000, RC_HARD);
    bus(1'b0, A_STK, 32'h0000_0000);
    chk(32'(rdat[7:6]), 32'h0000_0002);
    chk(32'(ctl.cfg_bits), 32'h0000_0000);
    e = base;
    e.stack_underflow = 1'b1;
    ev(e);
    chk(32'({ctl.pc_load, ctl.core_reset}), 32'h0000_0000);
    bus(1'b0, A_STK, 32'h0000_0000);
    chk(32'(rdat[7:6]), 32'h0000_0003);
    upset <= 2'h1;
    @(posedge core_clk);
    upset <= 2'h0;
    n = 0;
    while (ctl.cfg_reload !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(ctl.cfg_reload), 32'h0000_0001);
    run_wait();
    x[5] = 1'b0;
    reset_control_reg_is(x);
    $display("stack and mismatch test done");
    bus(1'b1, A_RESET_CONTROL_REG, 32'h0000_00ff);
    bor_det <= 1'b1;
    repeat (5) @(posedge core_clk);
    bor_det <= 1'b0;
    run_wait();
    bus(1'b0, A_RESET_CONTROL_REG, 32'h0000_0000);
    chk(32'(rdat[5:0]), 32'h0000_003e);
    chk(32'(rdat[1:0]), 32'h0000_0002);
    lpb <= 1'b1;
    repeat (5) @(posedge core_clk);
    lpb <= 1'b0;
    run_wait();
    reset_control_reg_is(8'h3c);
    $display("brown-out test done");
    fcfg <= 2'h1;
    pin_hold <= 1'b1;
    por <= 1'b1;
    repeat (4) @(posedge core_clk);
    por <= 1'b0;
    repeat (8400) @(posedge core_clk);
    bus(1'b0, A_STAT, 32'h0000_0000);
    chk(32'({rdat[17:16], ctl.core_reset}), 32'h0000_0007);
    pin_hold <= 1'b0;
    run_wait();
    chk(32'(n <= 7), 32'h0000_0001);
    $display("late pin test done");
    stop_test();
  end
endmodule : tb
